// File: src/pfl_pkg.sv
package pfl_pkg;
    // ===========================================================
    // Clock
    // ===========================================================
    localparam real CLK_PERIOD_NS = 20.0;

    // ===========================================================
    // Action-select codes and commands
    // ===========================================================
    localparam logic [1:0] ACT_ADDRESS = 2'h0;
    localparam logic [1:0] ACT_DATA = 2'h1;
    localparam logic [1:0] ACT_COMMAND = 2'h2;
    localparam logic [7:0] CMD_CHIP_ERASE = 8'h80;
    localparam logic [7:0] CMD_WRITE_FUSE = 8'h40;
    localparam logic [7:0] CMD_WRITE_LOCK = 8'h20;
    localparam logic [7:0] CMD_READ_STATUS = 8'h04;
    localparam logic [7:0] CMD_READ_SIGNATURE = 8'h08;
    localparam logic [7:0] SIG_LAST_ADDR = 8'h02;

    // ===========================================================
    // Field positions
    // ===========================================================
    localparam int FUSE_STARTUP_BIT = 0;
    localparam int FUSE_SERIAL_BIT = 5;
    localparam int LOCK_ONE_WR_BIT = 1;
    localparam int LOCK_TWO_WR_BIT = 2;
    localparam int ST_LOCK_ONE_BIT = 7;
    localparam int ST_LOCK_TWO_BIT = 6;
    localparam int ST_SERIAL_BIT = 5;
    localparam int ST_STARTUP_BIT = 0;

    // ===========================================================
    // Reset and fill values (1 means unprogrammed)
    // ===========================================================
    localparam logic [7:0] CMD_RESET = 8'h00;
    localparam logic [7:0] STATUS_RESERVED = 8'hFF;
    localparam logic [7:0] SIG_UNMAPPED = 8'hFF;

    // ===========================================================
    // Timing
    // ===========================================================
    localparam real T_WRITE_SELF_MS = 0.7;
    localparam real T_FUSE_PULSE_MIN_MS = 1.0;
    localparam real T_ERASE_PULSE_MIN_MS = 5.0;
    localparam int WRITE_SELF_CYC = int'($floor(T_WRITE_SELF_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int FUSE_PULSE_CYC = int'($ceil(T_FUSE_PULSE_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int ERASE_PULSE_CYC = int'($ceil(T_ERASE_PULSE_MIN_MS * 1.0e6 / CLK_PERIOD_NS));
    localparam int TIMER_W = 20;
endpackage : pfl_pkg

// File: src/pfl_top.sv
`timescale 1ns/100ps
// How it works
// - Fuse write takes startup-time fuse from data bit 0; other reserved bits ignored.
// - Fuse write needs a long write-strobe pulse; ready_busy stays high throughout.
// - Command byte 0x20 selects lock bit programming.
// - Lock write: zero in bit 2 programs lock two, bit 1 lock one.
// - Lock write starts by low-byte write strobe; ready_busy shows busy.
// - Programmed lock bits clear only through chip erase.
// - Command byte 0x04 reads fuse and lock status.
// - Status read with byte select high: lock1, lock2, serial fuse, startup fuse.
// - Output enable high releases the data bus within one clock.
// - Command byte 0x08 reads signature; low address 0x00 to 0x02 selects byte.
// - Signature read with byte select low drives the addressed byte.
// - Byte write makes ready_busy low until self-timed write ends.
// - Write strobe held past self-timed duration shows no busy pulse.
// - Action select 10 with byte select low and load strobe rising latches the command.
// - Action select 01 loads data; 00 with byte select low loads low address.
// - Fuse data zero programs, one erases; bit 5 is serial-programming fuse.
// - Command and address stay loaded across operations.
module pfl_top #(
    parameter int WRITE_SELF_CYCLES = pfl_pkg::WRITE_SELF_CYC,
    parameter int FUSE_PULSE_CYCLES = pfl_pkg::FUSE_PULSE_CYC,
    parameter int ERASE_PULSE_CYCLES = pfl_pkg::ERASE_PULSE_CYC,
    parameter logic [7:0] SIGNATURE_0 = 8'h5A, // Arbitrary value.
    parameter logic [7:0] SIGNATURE_1 = 8'hA5, // Arbitrary value.
    parameter logic [7:0] SIGNATURE_2 = 8'h3C, // Arbitrary value.
    parameter logic FUSE_STARTUP_INIT = 1'b1,
    parameter logic FUSE_SERIAL_INIT = 1'b0
) (
    input wire logic MCLK_I, // System clock.
    input wire logic RESET_I, // Synchronous reset, active high.
    input wire logic ACTION_SELECT_HIGH_I, // Action select, upper bit.
    input wire logic ACTION_SELECT_LOW_I, // Action select, lower bit.
    input wire logic BYTE_SELECT_I, // Byte select.
    input wire logic LOAD_STROBE_CLOCK_I, // Load strobe, rising edge loads.
    input wire logic WRITE_N_I, // Write strobe, active low.
    input wire logic OUTPUT_ENABLE_N_I, // Output enable, active low.
    input wire logic [7:0] DATA_I, // Data bus in.
    output logic [7:0] DATA_O, // Data bus out.
    output logic DATA_OE_O, // High while the device drives the data bus.
    output logic READY_BUSY_O, // Low while a byte write is in progress.
    output logic LOCK_BIT_ONE_O, // Lock bit one, 0 = programmed.
    output logic LOCK_BIT_TWO_O, // Lock bit two, 0 = programmed.
    output logic STARTUP_TIME_FUSE_O, // Startup-time fuse, 0 = programmed.
    output logic SERIAL_PROGRAM_ENABLE_FUSE_O // Serial programming fuse, 0 = programmed.
);
    import pfl_pkg::*;

    // ===========================================================
    // Parameter checks
    // ===========================================================
    generate
        if (WRITE_SELF_CYCLES < 1 || FUSE_PULSE_CYCLES < 1 || ERASE_PULSE_CYCLES < 1 ||
            WRITE_SELF_CYCLES >= (1 << TIMER_W) || FUSE_PULSE_CYCLES >= (1 << TIMER_W) ||
            ERASE_PULSE_CYCLES >= (1 << TIMER_W)) begin : g_bad_param
            $error("pfl_top: timing counts must lie between 1 and the timer range.");
        end
    endgenerate

    localparam logic [TIMER_W-1:0] WRITE_LIMIT = TIMER_W'(WRITE_SELF_CYCLES);
    localparam logic [TIMER_W-1:0] FUSE_LIMIT = TIMER_W'(FUSE_PULSE_CYCLES);
    localparam logic [TIMER_W-1:0] ERASE_LIMIT = TIMER_W'(ERASE_PULSE_CYCLES);

    typedef enum logic [1:0] {
        WS_IDLE,
        WS_STROBE_LOW,
        WS_BUSY
    } pfl_wstate_e;

    typedef struct packed {
        logic [7:0] command;
        logic [7:0] addr_low;
        logic [7:0] addr_high;
        logic [7:0] data_low;
        logic [7:0] data_high;
        logic load_prev;
        logic write_prev;
        pfl_wstate_e wstate;
        logic [TIMER_W-1:0] self_timer;
        logic [TIMER_W-1:0] pulse_timer;
        logic lock_pending;
        logic fuse_done;
        logic erase_done;
        logic lock_one;
        logic lock_two;
        logic fuse_startup;
        logic fuse_serial;
        logic ready_busy;
        logic [7:0] dout;
        logic doe;
    } pfl_state_s;

    pfl_state_s st_reg;
    pfl_state_s st_next;

    function automatic logic [TIMER_W-1:0] pfl_bump(input logic [TIMER_W-1:0] count,
                                                    input logic [TIMER_W-1:0] limit);
        pfl_bump = (count < limit) ? count + TIMER_W'(1) : count;
    endfunction : pfl_bump

    // ===========================================================
    // Next-state logic
    // ===========================================================
    always_comb begin
        logic [1:0] action;
        logic load_rise;
        logic write_fall;
        logic write_rise;
        action = {ACTION_SELECT_HIGH_I, ACTION_SELECT_LOW_I};
        load_rise = LOAD_STROBE_CLOCK_I && !st_reg.load_prev;
        write_fall = !WRITE_N_I && st_reg.write_prev;
        write_rise = WRITE_N_I && !st_reg.write_prev;
        st_next = st_reg;
        st_next.load_prev = LOAD_STROBE_CLOCK_I;
        st_next.write_prev = WRITE_N_I;

        // Loads through the load strobe; everything is held until reloaded.
        if (load_rise) begin
            case (action)
                ACT_COMMAND: begin
                    if (!BYTE_SELECT_I) begin
                        st_next.command = DATA_I;
                    end
                end
                ACT_DATA: begin
                    if (BYTE_SELECT_I) begin
                        st_next.data_high = DATA_I;
                    end else begin
                        st_next.data_low = DATA_I;
                    end
                end
                ACT_ADDRESS: begin
                    if (BYTE_SELECT_I) begin
                        st_next.addr_high = DATA_I;
                    end else begin
                        st_next.addr_low = DATA_I;
                    end
                end
                default: begin
                end
            endcase
        end

        // Fuse write and chip erase act once the strobe has been low long enough.
        if (WRITE_N_I) begin
            st_next.pulse_timer = '0;
            st_next.fuse_done = 1'b0;
            st_next.erase_done = 1'b0;
        end else begin
            st_next.pulse_timer = pfl_bump(st_reg.pulse_timer, ERASE_LIMIT);
            if (st_reg.command == CMD_WRITE_FUSE && !st_reg.fuse_done &&
                st_reg.pulse_timer >= FUSE_LIMIT - TIMER_W'(1)) begin
                st_next.fuse_done = 1'b1;
                st_next.fuse_startup = st_reg.data_low[FUSE_STARTUP_BIT];
                st_next.fuse_serial = st_reg.data_low[FUSE_SERIAL_BIT];
            end
            if (st_reg.command == CMD_CHIP_ERASE && !st_reg.erase_done &&
                st_reg.pulse_timer >= ERASE_LIMIT - TIMER_W'(1)) begin
                st_next.erase_done = 1'b1;
                st_next.lock_one = 1'b1;
                st_next.lock_two = 1'b1;
            end
        end

        // Self-timed byte write: busy shows only after the strobe rises early.
        case (st_reg.wstate)
            WS_IDLE: begin
                if (write_fall && !BYTE_SELECT_I && st_reg.command == CMD_WRITE_LOCK) begin
                    st_next.wstate = WS_STROBE_LOW;
                    st_next.self_timer = TIMER_W'(1);
                    st_next.lock_pending = 1'b1;
                end
            end
            WS_STROBE_LOW: begin
                st_next.self_timer = st_reg.self_timer + TIMER_W'(1);
                if (st_reg.self_timer >= WRITE_LIMIT) begin
                    st_next.wstate = WS_IDLE;
                end else if (write_rise) begin
                    st_next.wstate = WS_BUSY;
                    st_next.ready_busy = 1'b0;
                end
            end
            WS_BUSY: begin
                st_next.self_timer = st_reg.self_timer + TIMER_W'(1);
                if (st_reg.self_timer >= WRITE_LIMIT) begin
                    st_next.wstate = WS_IDLE;
                    st_next.ready_busy = 1'b1;
                end
            end
            default: begin
                st_next.wstate = WS_IDLE;
                st_next.ready_busy = 1'b1;
            end
        endcase
        if (st_reg.lock_pending && st_next.wstate == WS_IDLE) begin
            st_next.lock_pending = 1'b0;
            // Only programming is possible here; a one never erases a lock bit.
            st_next.lock_one = st_reg.lock_one & st_reg.data_low[LOCK_ONE_WR_BIT];
            st_next.lock_two = st_reg.lock_two & st_reg.data_low[LOCK_TWO_WR_BIT];
        end

        // Read path.
        st_next.doe = 1'b0;
        st_next.dout = st_reg.dout;
        if (!OUTPUT_ENABLE_N_I) begin
            if (st_reg.command == CMD_READ_STATUS && BYTE_SELECT_I) begin
                st_next.doe = 1'b1;
                st_next.dout = STATUS_RESERVED;
                st_next.dout[ST_LOCK_ONE_BIT] = st_reg.lock_one;
                st_next.dout[ST_LOCK_TWO_BIT] = st_reg.lock_two;
                st_next.dout[ST_SERIAL_BIT] = st_reg.fuse_serial;
                st_next.dout[ST_STARTUP_BIT] = st_reg.fuse_startup;
            end else if (st_reg.command == CMD_READ_SIGNATURE && !BYTE_SELECT_I) begin
                st_next.doe = 1'b1;
                case (st_reg.addr_low)
                    8'h00: st_next.dout = SIGNATURE_0;
                    8'h01: st_next.dout = SIGNATURE_1;
                    SIG_LAST_ADDR: st_next.dout = SIGNATURE_2;
                    default: st_next.dout = SIG_UNMAPPED;
                endcase
            end
        end
        if (OUTPUT_ENABLE_N_I) begin
            st_next.doe = 1'b0;
        end
    end

    // ===========================================================
    // State register
    // ===========================================================
    always_ff @(posedge MCLK_I) begin
        if (RESET_I) begin
            st_reg <= '{
                command: CMD_RESET,
                addr_low: 8'h00,
                addr_high: 8'h00,
                data_low: 8'hFF,
                data_high: 8'hFF,
                load_prev: 1'b0,
                write_prev: 1'b1,
                wstate: WS_IDLE,
                self_timer: '0,
                pulse_timer: '0,
                lock_pending: 1'b0,
                fuse_done: 1'b0,
                erase_done: 1'b0,
                lock_one: 1'b1,
                lock_two: 1'b1,
                fuse_startup: FUSE_STARTUP_INIT,
                fuse_serial: FUSE_SERIAL_INIT,
                ready_busy: 1'b1,
                dout: 8'h00,
                doe: 1'b0
            };
        end else begin
            st_reg <= st_next;
        end
    end

    assign DATA_O = st_reg.dout;
    assign DATA_OE_O = st_reg.doe;
    assign READY_BUSY_O = st_reg.ready_busy;
    assign LOCK_BIT_ONE_O = st_reg.lock_one;
    assign LOCK_BIT_TWO_O = st_reg.lock_two;
    assign STARTUP_TIME_FUSE_O = st_reg.fuse_startup;
    assign SERIAL_PROGRAM_ENABLE_FUSE_O = st_reg.fuse_serial;
endmodule : pfl_top

// File: testbench/parallel_fuse_lock_signature_access_bench.sv
`timescale 1ns/100ps
module parallel_fuse_lock_signature_access_bench;
    import pfl_pkg::*;
    localparam int WS = 20;
    localparam logic [7:0] SIG [4] = '{8'h5A, 8'hA5, 8'h3C, 8'hFF};
    logic mclk, rst, ahi, alo, bs, ld, wn, oen, pen, doe, rb, l1, l2, fs, fsp, oe, off;
    logic [7:0] pd, dout, rd;
    wire [7:0] bus;
    int err_count, n_compared, busy, last;
    assign bus = doe ? dout : (pen ? pd : ~pd);
    pfl_top #(.WRITE_SELF_CYCLES(WS), .FUSE_PULSE_CYCLES(30), .ERASE_PULSE_CYCLES(60), .SIGNATURE_0(SIG[0]),
        .SIGNATURE_1(SIG[1]), .SIGNATURE_2(SIG[2])) u_pfl_top (.MCLK_I(mclk), .RESET_I(rst),
        .ACTION_SELECT_HIGH_I(ahi), .ACTION_SELECT_LOW_I(alo), .BYTE_SELECT_I(bs), .LOAD_STROBE_CLOCK_I(ld),
        .WRITE_N_I(wn), .OUTPUT_ENABLE_N_I(oen), .DATA_I(bus), .DATA_O(dout), .DATA_OE_O(doe),
        .READY_BUSY_O(rb), .LOCK_BIT_ONE_O(l1), .LOCK_BIT_TWO_O(l2), .STARTUP_TIME_FUSE_O(fs),
        .SERIAL_PROGRAM_ENABLE_FUSE_O(fsp));
    pfl_programmer u_pfl_programmer (.clk_i(mclk), .rb_i(rb), .oe_i(doe), .data_i(bus), .ahi_o(ahi),
        .alo_o(alo), .bs_o(bs), .ld_o(ld), .wn_o(wn), .oen_o(oen), .d_o(pd), .en_o(pen));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("compared %0d mismatched %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic t_status(input logic [7:0] exp);
        u_pfl_programmer.load(ACT_COMMAND, 1'b0, CMD_READ_STATUS);
        u_pfl_programmer.rd(1'b1, rd, oe, off);
        chk(rd, exp);
        chk({6'h0, oe, off}, 8'h02);
        u_pfl_programmer.rd(1'b0, rd, oe, off);
        chk({7'h0, oe}, 8'h00);
    endtask : t_status
    task automatic t_sig();
        u_pfl_programmer.load(ACT_COMMAND, 1'b0, CMD_READ_SIGNATURE);
        // A command load with byte select high must be ignored, so the signature command stays.
        u_pfl_programmer.load(ACT_COMMAND, 1'b1, CMD_READ_STATUS);
        for (int a = 0; a < 4; a++) begin
            u_pfl_programmer.load(ACT_ADDRESS, 1'b0, 8'(a));
            u_pfl_programmer.rd(1'b0, rd, oe, off);
            chk(rd, SIG[a]);
            chk({6'h0, oe, off}, 8'h02);
        end
    endtask : t_sig
    task automatic t_fuse();
        u_pfl_programmer.load(ACT_COMMAND, 1'b0, CMD_WRITE_FUSE);
        u_pfl_programmer.load(ACT_DATA, 1'b0, 8'hFE);
        u_pfl_programmer.wr(10, busy, last);
        chk({5'h0, busy > 0, fs, fsp}, 8'h02);
        u_pfl_programmer.wr(35, busy, last);
        chk({5'h0, busy > 0, fs, fsp}, 8'h01);
    endtask : t_fuse
    task automatic t_lock();
        u_pfl_programmer.load(ACT_COMMAND, 1'b0, CMD_WRITE_LOCK);
        u_pfl_programmer.load(ACT_DATA, 1'b0, 8'hFD);
        u_pfl_programmer.wr(3, busy, last);
        chk({5'h0, busy > 0, last >= WS - 1 && last <= WS + 2, 1'b0}, 8'h06);
        chk({6'h0, l1, l2}, 8'h01);
        u_pfl_programmer.load(ACT_DATA, 1'b0, 8'hFB);
        u_pfl_programmer.wr(WS + 10, busy, last);
        chk({5'h0, busy > 0, l1, l2}, 8'h00);
        u_pfl_programmer.load(ACT_DATA, 1'b0, 8'hFF);
        u_pfl_programmer.wr(3, busy, last);
        chk({6'h0, l1, l2}, 8'h00);
    endtask : t_lock
    task automatic t_erase();
        u_pfl_programmer.load(ACT_COMMAND, 1'b0, CMD_CHIP_ERASE);
        u_pfl_programmer.wr(70, busy, last);
        chk({3'h0, busy > 0, l1, l2, fs, fsp}, 8'h0D);
    endtask : t_erase
    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end
    initial begin
        rst = 1'b1;
        err_count = 0;
        n_compared = 0;
        repeat (20) @(posedge mclk);
        rst <= 1'b0;
        t_status(8'hDF);
        t_sig();
        t_fuse();
        t_lock();
        t_status(8'h3E);
        t_erase();
        t_status(8'hFE);
        close_out();
    end
    initial begin
        #400000;
        err_count++;
        close_out();
    end
endmodule : parallel_fuse_lock_signature_access_bench
bind pfl_top pfl_properties #(.WRITE_SELF_CYCLES(WRITE_SELF_CYCLES), .FUSE_PULSE_CYCLES(FUSE_PULSE_CYCLES),
    .ERASE_PULSE_CYCLES(ERASE_PULSE_CYCLES)) u_pfl_properties (.MCLK_I(MCLK_I), .RESET_I(RESET_I),
    .BYTE_SELECT_I(BYTE_SELECT_I), .WRITE_N_I(WRITE_N_I), .OUTPUT_ENABLE_N_I(OUTPUT_ENABLE_N_I),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .READY_BUSY_O(READY_BUSY_O), .LOCK_BIT_ONE_O(LOCK_BIT_ONE_O),
    .LOCK_BIT_TWO_O(LOCK_BIT_TWO_O), .STARTUP_TIME_FUSE_O(STARTUP_TIME_FUSE_O),
    .SERIAL_PROGRAM_ENABLE_FUSE_O(SERIAL_PROGRAM_ENABLE_FUSE_O));

// File: testbench/pfl_programmer.sv
`timescale 1ns/100ps
module pfl_programmer (
    input wire logic clk_i, // Clock.
    input wire logic rb_i, // Ready/busy.
    input wire logic oe_i, // Device drive enable.
    input wire logic [7:0] data_i, // Resolved bus.
    output logic ahi_o, // Action high.
    output logic alo_o, // Action low.
    output logic bs_o, // Byte select.
    output logic ld_o, // Load strobe.
    output logic wn_o, // Write strobe.
    output logic oen_o, // Output enable.
    output logic [7:0] d_o, // Bus value.
    output logic en_o // Drives bus.
);
    initial begin
        {ahi_o, alo_o, bs_o, ld_o} = 4'h0;
        {wn_o, oen_o, en_o} = 3'h6;
        d_o = 8'h00;
    end
    task automatic load(input logic [1:0] act, input logic bsel, input logic [7:0] val);
        @(posedge clk_i);
        {ahi_o, alo_o} <= act;
        bs_o <= bsel;
        d_o <= val;
        en_o <= 1'b1;
        @(posedge clk_i);
        ld_o <= 1'b1;
        @(posedge clk_i);
        ld_o <= 1'b0;
        @(posedge clk_i);
        en_o <= 1'b0;
    endtask : load
    task automatic rd(input logic bsel, output logic [7:0] val, output logic oe, output logic off);
        @(posedge clk_i);
        bs_o <= bsel;
        oen_o <= 1'b0;
        repeat (2) @(posedge clk_i);
        #1;
        val = data_i;
        oe = oe_i;
        @(posedge clk_i);
        oen_o <= 1'b1;
        @(posedge clk_i);
        #1;
        off = oe_i;
    endtask : rd
    task automatic wr(input int n, output int busy, output int last);
        busy = 0;
        last = 0;
        @(posedge clk_i);
        bs_o <= 1'b0;
        wn_o <= 1'b0;
        for (int k = 1; k <= n + 40; k++) begin
            @(posedge clk_i);
            if (k == n) begin
                wn_o <= 1'b1;
            end
            #1;
            if (rb_i !== 1'b1) begin
                busy++;
                last = k;
            end
        end
    endtask : wr
endmodule : pfl_programmer

// File: testbench/pfl_properties.sv
`timescale 1ns/100ps
module pfl_properties #(
    parameter int WRITE_SELF_CYCLES = 20,
    parameter int FUSE_PULSE_CYCLES = 30,
    parameter int ERASE_PULSE_CYCLES = 60
) (
    input wire logic MCLK_I, // Clock.
    input wire logic RESET_I, // Reset.
    input wire logic BYTE_SELECT_I, // Byte select.
    input wire logic WRITE_N_I, // Write strobe.
    input wire logic OUTPUT_ENABLE_N_I, // Output enable.
    input wire logic [7:0] DATA_O, // Data out.
    input wire logic DATA_OE_O, // Drive enable.
    input wire logic READY_BUSY_O, // Ready/busy.
    input wire logic LOCK_BIT_ONE_O, // Lock one.
    input wire logic LOCK_BIT_TWO_O, // Lock two.
    input wire logic STARTUP_TIME_FUSE_O, // Startup fuse.
    input wire logic SERIAL_PROGRAM_ENABLE_FUSE_O // Serial fuse.
);
    localparam int BUSY_MAX = WRITE_SELF_CYCLES + 2;
    int wlow_cnt;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RESET_I);
    // Counts edges of an unbroken low write strobe.
    always_ff @(posedge MCLK_I) begin
        if (RESET_I || WRITE_N_I) begin
            wlow_cnt <= 0;
        end else begin
            wlow_cnt <= wlow_cnt + 1;
        end
    end
    a_bus_release: assert property (OUTPUT_ENABLE_N_I |=> !DATA_OE_O) else $error("bus kept");
    a_drive_cause: assert property (DATA_OE_O |-> !$past(OUTPUT_ENABLE_N_I)) else $error("bus driven");
    a_status_map: assert property (DATA_OE_O && $past(BYTE_SELECT_I) |-> DATA_O == {$past(LOCK_BIT_ONE_O),
        $past(LOCK_BIT_TWO_O), $past(SERIAL_PROGRAM_ENABLE_FUSE_O), 4'hF, $past(STARTUP_TIME_FUSE_O)})
        else $error("status byte wrong");
    a_busy_after: assert property ($fell(READY_BUSY_O) |-> $past(WRITE_N_I)) else $error("busy early");
    a_busy_bound: assert property ($fell(READY_BUSY_O) |-> ##[1:BUSY_MAX] READY_BUSY_O) else $error("busy long");
    a_long_quiet: assert property (wlow_cnt > WRITE_SELF_CYCLES |-> READY_BUSY_O) else $error("busy shown");
    a_lock_erase: assert property ($rose(LOCK_BIT_ONE_O) || $rose(LOCK_BIT_TWO_O)
        |-> $past(wlow_cnt) >= ERASE_PULSE_CYCLES - 2) else $error("lock cleared");
    a_fuse_quiet: assert property ($changed(STARTUP_TIME_FUSE_O) || $changed(SERIAL_PROGRAM_ENABLE_FUSE_O)
        |-> READY_BUSY_O && $past(wlow_cnt) >= FUSE_PULSE_CYCLES - 2) else $error("fuse change");
    c_busy: cover property ($fell(READY_BUSY_O));
    c_status: cover property (DATA_OE_O && $past(BYTE_SELECT_I));
    c_erase: cover property ($rose(LOCK_BIT_ONE_O));
    c_fuse: cover property ($changed(STARTUP_TIME_FUSE_O));
endmodule : pfl_properties
